// ---- core/srr_reset_unit.sv ----
// Purpose: low-supply reset and runaway-detection counter with control byte
// Assumes: supply_low_in and osc_clk_in are asynchronous pins
// Notes:   control byte is reached through a plain byte port, no bus decode
// Operation
// - supply low sets flag, asserts reset
// - detector works in stop, wakes device
// - delay supply reset until RAM write ends
// - ignore supply request during reset output
// - 20-bit counter on oscillation clock edges
// - counter runs after power-on without enable
// - expiry without clear asserts internal reset
// - runaway reset lasts five machine cycles
// - standby return adds 20 us margin
// - no counting while CPU stopped
// - clear on write zero, reset, osc stop, sleep, timebase/watch
// - control byte at 0x6E, resets to 00111000
`timescale 1ns/1ps
module srr_reset_unit (
  input  wire logic       clk_sys_in,
  input  wire logic       nrst_in,
  input  wire logic       supply_low_in,
  input  wire logic       osc_clk_in,
  input  wire logic       osc_stopped_in,
  input  wire logic       cpu_stopped_in,
  input  wire logic       stop_mode_in,
  input  wire logic       enter_sleep_in,
  input  wire logic       enter_timebase_in,
  input  wire logic       enter_watch_in,
  input  wire logic       standby_exit_in,
  input  wire logic       ram_write_in,
  input  wire logic       ctrl_wr_in,
  input  wire logic [7:0] ctrl_addr_in,
  input  wire logic [7:0] ctrl_wdata_in,
  output logic      [7:0] ctrl_rdata_out,
  output logic            int_reset_out,
  output logic            stop_release_out,
  output logic            supply_low_flag_out
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic supply_low_sync;
  logic osc_sync;

  srr_sync2 u_sync_supply (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .async_in   (supply_low_in),
    .sync_out   (supply_low_sync)
  );

  srr_sync2 u_sync_osc (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .async_in   (osc_clk_in),
    .sync_out   (osc_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]                     ctrl_reg,  ctrl_next;
  logic [srr_pkg::CNT_W-1:0]      cnt_reg,   cnt_next;
  logic                           wrap_reg,  wrap_next;
  logic [srr_pkg::EXTRA_W-1:0]    extra_reg, extra_next;
  logic                           osc_d_reg, osc_d_next;
  logic [srr_pkg::PULSE_W-1:0]    pulse_reg, pulse_next;
  srr_pkg::srr_state_t            state_reg, state_next;
  logic                           wake_reg,  wake_next;

  logic osc_rise;
  logic ctrl_hit;
  logic sw_clear;
  logic cnt_clear;
  logic expire;
  logic low_req;

  assign osc_rise = osc_sync & ~osc_d_reg;
  assign ctrl_hit = ctrl_wr_in && (ctrl_addr_in == srr_pkg::CTRL_OFFSET);
  // clear bit only acts when written as zero
  assign sw_clear = ctrl_hit && !ctrl_wdata_in[srr_pkg::CLEAR_BIT];
  assign cnt_clear = sw_clear || int_reset_out || osc_stopped_in ||
                     enter_sleep_in || enter_timebase_in || enter_watch_in;
  // expiry waits out the extra margin granted after standby
  assign expire = wrap_reg && (extra_reg == '0);
  // supply request is masked while any reset pulse is out
  assign low_req = supply_low_sync && (state_reg == srr_pkg::SRR_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // runaway counter

  always_comb begin
    osc_d_next = osc_sync;
    cnt_next   = cnt_reg;
    wrap_next  = wrap_reg;
    extra_next = extra_reg;
    if (standby_exit_in) begin
      extra_next = srr_pkg::EXTRA_W'(srr_pkg::EXTRA_CYCLES);
    end else if (sw_clear || int_reset_out) begin
      // margin is dropped only by a software clear or internal reset; other counter clears keep it
      extra_next = '0;
    end else if (wrap_reg && extra_reg != '0 && !cpu_stopped_in) begin
      extra_next = extra_reg - 1'b1;
    end
    if (cnt_clear) begin
      cnt_next  = '0;
      wrap_next = 1'b0;
    end else if (osc_rise && !cpu_stopped_in && !wrap_reg) begin
      cnt_next = cnt_reg + 1'b1;
      if (cnt_reg == {srr_pkg::CNT_W{1'b1}}) begin
        wrap_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      osc_d_reg <= 1'b0;
      cnt_reg   <= '0;
      wrap_reg  <= 1'b0;
      extra_reg <= '0;
    end else begin
      osc_d_reg <= osc_d_next;
      cnt_reg   <= cnt_next;
      wrap_reg  <= wrap_next;
      extra_reg <= extra_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset pulse sequencer

  always_comb begin
    state_next = state_reg;
    pulse_next = pulse_reg;
    wake_next  = 1'b0;
    case (state_reg)
      srr_pkg::SRR_IDLE: begin
        if (low_req) begin
          wake_next = stop_mode_in;
          if (ram_write_in) begin
            state_next = srr_pkg::SRR_WAIT_WRITE;
          end else begin
            state_next = srr_pkg::SRR_PULSE;
            pulse_next = srr_pkg::PULSE_W'(srr_pkg::RST_CYCLES - 1);
          end
        end else if (expire) begin
          state_next = srr_pkg::SRR_PULSE;
          pulse_next = srr_pkg::PULSE_W'(srr_pkg::RST_CYCLES - 1);
        end
      end
      srr_pkg::SRR_WAIT_WRITE: begin
        if (!ram_write_in) begin
          state_next = srr_pkg::SRR_PULSE;
          pulse_next = srr_pkg::PULSE_W'(srr_pkg::RST_CYCLES - 1);
        end
      end
      srr_pkg::SRR_PULSE: begin
        if (pulse_reg == '0) begin
          state_next = srr_pkg::SRR_IDLE;
        end else begin
          pulse_next = pulse_reg - 1'b1;
        end
      end
      default: begin
        state_next = srr_pkg::SRR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      state_reg <= srr_pkg::SRR_IDLE;
      pulse_reg <= '0;
      wake_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      pulse_reg <= pulse_next;
      wake_reg  <= wake_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control byte

  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_hit) begin
      // flag is cleared by writing zero; clear bit always reads back zero
      ctrl_next = ctrl_wdata_in | srr_pkg::CTRL_RESET;
      ctrl_next[srr_pkg::FLAG_BIT] = ctrl_reg[srr_pkg::FLAG_BIT] &
                                     ctrl_wdata_in[srr_pkg::FLAG_BIT];
      ctrl_next[srr_pkg::CLEAR_BIT] = 1'b0;
    end
    // set wins over a same-cycle software clear
    if (low_req) begin
      ctrl_next[srr_pkg::FLAG_BIT] = 1'b1;
    end
  end

  // flag survives the pulse it causes; only a zero write or system reset clears it
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      ctrl_reg <= srr_pkg::CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign ctrl_rdata_out      = ctrl_reg;
  assign supply_low_flag_out = ctrl_reg[srr_pkg::FLAG_BIT];
  assign int_reset_out       = (state_reg == srr_pkg::SRR_PULSE);
  assign stop_release_out    = wake_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_low_seen;
    (state_reg == srr_pkg::SRR_IDLE) && supply_low_sync && !ram_write_in;
  endsequence

  sequence s_five_wide;
    int_reset_out [*5] ##1 !int_reset_out;
  endsequence

  a_low_sets_flag: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    s_low_seen |=> supply_low_flag_out && int_reset_out)
    else $error("supply low did not set flag and reset");

  a_stop_wake: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    s_low_seen ##0 stop_mode_in |=> stop_release_out)
    else $error("stop mode not released on supply low");

  a_write_holds: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    (state_reg == srr_pkg::SRR_WAIT_WRITE) && ram_write_in |=> !int_reset_out)
    else $error("reset raised during ram write");

  a_pulse_masks: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    int_reset_out && $past(int_reset_out) |-> !wake_reg)
    else $error("supply request accepted during reset");

  a_pulse_width: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    $rose(int_reset_out) |-> s_five_wide)
    else $error("reset pulse not five cycles");

  a_no_count_stop: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    cpu_stopped_in && !cnt_clear |=> $stable(cnt_reg))
    else $error("counter moved while cpu stopped");

  a_clear_zero: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    cnt_clear |=> cnt_reg == '0 && !wrap_reg)
    else $error("counter not cleared");

  a_expire_reset: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    expire && (state_reg == srr_pkg::SRR_IDLE) && !supply_low_sync |=> int_reset_out)
    else $error("expiry without reset");

  a_count_step: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    osc_rise && !cpu_stopped_in && !cnt_clear && !wrap_reg |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("counter did not advance");

endmodule : srr_reset_unit

// ---- core/srr_pkg.sv ----
// Purpose: shared constants for the supply and runaway reset unit
// Assumes: 40 MHz system clock; oscillation clock arrives as a pin level
// Notes:   control byte layout is fixed at reset value 00111000
package srr_pkg;

  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam logic [7:0]  CTRL_OFFSET      = 8'h6E;
  localparam logic [7:0]  CTRL_RESET       = 8'h38;
  localparam int unsigned FLAG_BIT         = 7;
  localparam int unsigned CLEAR_BIT        = 6;
  localparam int unsigned CNT_W            = 20;
  localparam int unsigned RST_CYCLES       = 5;
  localparam int unsigned PULSE_W          = 3;
  localparam int unsigned EXTRA_NS         = 20_000;
  // extra standby margin: 20 us at 40 MHz, longest time so rounded down
  localparam int unsigned EXTRA_CYCLES_RAW = EXTRA_NS / (1_000_000_000 / CLK_HZ);
  localparam int unsigned EXTRA_CYCLES     = (EXTRA_CYCLES_RAW < 1) ? 1 : EXTRA_CYCLES_RAW;
  localparam int unsigned EXTRA_W          = 10;

  typedef enum logic [1:0] {
    SRR_IDLE,
    SRR_WAIT_WRITE,
    SRR_PULSE
  } srr_state_t;

endpackage : srr_pkg

// ---- core/srr_sync2.sv ----
// Purpose: two-flop synchroniser for one asynchronous level
// Assumes: destination clock is the system clock
// Notes:   first flop is read only by the second
`timescale 1ns/1ps
module srr_sync2 (
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule : srr_sync2

// ---- tb/srr_supply_model.sv ----
// Purpose: far-side model: supply comparator and oscillation source
// Assumes: bench clock paces both outputs
// Notes:   osc pin stands still at 0 while not running
`timescale 1ns/1ps
module srr_supply_model (
  input  wire logic clk_sys_in,
  input  wire logic low_req_in,
  input  wire logic osc_run_in,
  output logic      supply_low_out,
  output logic      osc_clk_out
);
  ////////////////////////////////////////////////////////////////////////
  logic [2:0] div_reg;

  initial begin
    div_reg        = 3'h0;
    supply_low_out = 1'b0;
    osc_clk_out    = 1'b0;
  end

  // divide by 8 keeps osc well under clk/4 so every edge is seen
  always @(posedge clk_sys_in) begin
    supply_low_out <= low_req_in;
    div_reg        <= osc_run_in ? div_reg + 3'h1 : 3'h0;
    osc_clk_out    <= osc_run_in & div_reg[2];
  end
endmodule : srr_supply_model

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the supply and runaway reset unit
// Assumes: 40 MHz clock, reset held 6 cycles
// Notes:   full 2^20 runaway expiry is out of reach in run length
`timescale 1ns/1ps
module testbench;
  logic       clk_sys, nrst, low_req, osc_run, osc_stopped, cpu_stopped;
  logic       stop_mode, ram_write, ctrl_wr, supply_low, osc_clk;
  logic [3:0] ev;
  logic [7:0] ctrl_addr, ctrl_wdata, ctrl_rdata;
  logic       int_reset, stop_release, flag;
  int         n_errors, check_count;

  srr_supply_model srr_supply_model_i (.clk_sys_in(clk_sys), .low_req_in(low_req),
    .osc_run_in(osc_run), .supply_low_out(supply_low), .osc_clk_out(osc_clk));

  srr_reset_unit srr_reset_unit_i (.clk_sys_in(clk_sys), .nrst_in(nrst),
    .supply_low_in(supply_low), .osc_clk_in(osc_clk), .osc_stopped_in(osc_stopped),
    .cpu_stopped_in(cpu_stopped), .stop_mode_in(stop_mode), .enter_sleep_in(ev[0]),
    .enter_timebase_in(ev[1]), .enter_watch_in(ev[2]), .standby_exit_in(ev[3]),
    .ram_write_in(ram_write), .ctrl_wr_in(ctrl_wr), .ctrl_addr_in(ctrl_addr),
    .ctrl_wdata_in(ctrl_wdata), .ctrl_rdata_out(ctrl_rdata), .int_reset_out(int_reset),
    .stop_release_out(stop_release), .supply_low_flag_out(flag));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    ctrl_wr    <= 1'b1;
    ctrl_addr  <= a;
    ctrl_wdata <= d;
    @(posedge clk_sys);
    ctrl_wr    <= 1'b0;
    tick(1);
  endtask : wr

  task automatic summarize;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_and_write;
    check("ctrl at reset", ctrl_rdata, srr_pkg::CTRL_RESET);
    check("flag at reset", flag, 8'h00);
    wr(8'h6D, 8'hC7);
    check("ctrl after stray write", ctrl_rdata, 8'h38);
    wr(8'h6E, 8'h47);
    check("ctrl after write", ctrl_rdata, 8'h3F);
    wr(8'h6E, 8'h00);
    check("ctrl after clear write", ctrl_rdata, 8'h38);
  endtask : t_reset_and_write

  // supply held low through the whole pulse: a second request must not stretch it
  task automatic t_supply(input logic stop, input logic ram);
    int   n;
    int   w;
    logic rel;
    n = 0;
    w = 0;
    @(posedge clk_sys);
    stop_mode <= stop;
    ram_write <= ram;
    low_req   <= 1'b1;
    if (ram) begin
      tick(8);
      check("reset during ram write", int_reset, 8'h00);
      @(posedge clk_sys);
      ram_write <= 1'b0;
    end
    while (int_reset !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    rel = stop_release;
    check("ctrl on supply low", ctrl_rdata, 8'hB8);
    check("stop release", rel, 8'(stop));
    while (int_reset === 1'b1 && w < 20) begin
      tick(1);
      w++;
    end
    check("supply reset width", 8'(w), 8'(srr_pkg::RST_CYCLES));
    @(posedge clk_sys);
    low_req   <= 1'b0;
    stop_mode <= 1'b0;
    tick(20);
    wr(8'h6E, 8'h40);
    check("flag after clear", flag, 8'h00);
  endtask : t_supply

  task automatic t_counter_events;
    logic [19:0] c0;
    @(posedge clk_sys);
    osc_run <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      tick(200);
      check("cnt running", 8'(srr_reset_unit_i.cnt_reg != 0), 8'h01);
      @(posedge clk_sys);
      ev <= 4'h1 << i;
      @(posedge clk_sys);
      ev <= 4'h0;
      #1;
      if (i < 3) check("cnt after mode", 8'(srr_reset_unit_i.cnt_reg == 0), 8'h01);
    end
    check("standby margin", 8'(srr_reset_unit_i.extra_reg == srr_pkg::EXTRA_CYCLES),
          8'h01);
    @(posedge clk_sys);
    cpu_stopped <= 1'b1;
    tick(2);
    c0 = srr_reset_unit_i.cnt_reg;
    tick(300);
    check("cnt while cpu stopped", 8'(srr_reset_unit_i.cnt_reg == c0), 8'h01);
    c0 = srr_reset_unit_i.cnt_reg;
    @(posedge clk_sys);
    cpu_stopped <= 1'b0;
    // model osc runs at clk/8: 80 cycles hold exactly ten rising edges
    tick(80);
    check("osc edges counted", 8'(srr_reset_unit_i.cnt_reg - c0), 8'h0A);
    @(posedge clk_sys);
    osc_stopped <= 1'b1;
    tick(2);
    check("cnt after osc stop", 8'(srr_reset_unit_i.cnt_reg == 0), 8'h01);
    tick(100);
    @(posedge clk_sys);
    osc_stopped <= 1'b0;
    tick(40);
    wr(8'h6E, 8'h00);
    check("cnt after sw clear", 8'(srr_reset_unit_i.cnt_reg < 2), 8'h01);
    check("margin after sw clear", 8'(srr_reset_unit_i.extra_reg == 0), 8'h01);
    tick(2000);
    check("no early runaway reset", int_reset, 8'h00);
    check("ctrl after mode events", ctrl_rdata, 8'h38);
  endtask : t_counter_events

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    summarize();
  end

  initial begin
    {nrst, low_req, osc_run, osc_stopped, cpu_stopped, stop_mode} = 6'h00;
    {ram_write, ctrl_wr, ev, ctrl_addr, ctrl_wdata} = 22'h000000;
    n_errors    = 0;
    check_count = 0;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    tick(2);
    t_reset_and_write();
    t_supply(1'b0, 1'b0);
    t_supply(1'b1, 1'b0);
    t_supply(1'b0, 1'b1);
    t_counter_events();
    summarize();
  end
endmodule : testbench
